// file: hw/dbi_pin_sync.sv
// Two-flop synchroniser with falling-edge pulses.
// Assumes reset_n is synchronous to clk.
module dbi_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic clk,
   input wire logic reset_n,
   dbi_sync_if.sync pins
);
   logic [W-1:0] meta_r;
   logic [W-1:0] level_r;
   logic [W-1:0] last_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         meta_r <= INIT;
         level_r <= INIT;
         last_r <= INIT;
      end else begin
         meta_r <= pins.raw;
         level_r <= meta_r;
         last_r <= level_r;
      end
   end

   assign pins.level = level_r;
   assign pins.fall = last_r & ~level_r;
endmodule

// file: hw/dbi_pins.sv
// External bus, interrupt and restart pin logic with register slave.
// Assumes an Avalon-MM master on clk; all pins asynchronous to clk.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`include "dbi_regs.svh"

// Notes on behaviour
// - Address lines 15..0 carry program, data or I/O addresses.
// - Lines 22..16 are driven only for program-space accesses.
// - In hold the whole address bus is released.
// - A low float-all input releases address and data buses.
// - In wide host mode lines 16..0 are inputs for host addressing.
// - The address holder keeps the last level on undriven lines.
// - Data words move 16 bits wide between core and bus.
// - Data lines float unless writing, and during restart or hold.
// - The data holder keeps the last level; it is on from reset and restart, and software can switch it off.
// - Acceptance drives the acknowledge low with the vector on 15..0.
// - A low float-all input releases the acknowledge output.
// - Four user interrupts are maskable and ordered by a mode bit.
// - Pending user interrupts show in a flag register, clearable.
// - The nonmaskable interrupt ignores both masks and has its vector.
// - Restart stops activity, loads FF80h and resets state.
module dbi_pins (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic [22:0] addr_in,
   output logic [22:0] addr_out,
   output logic [22:0] addr_oe,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe,
   output logic data_hold_en,
   input wire logic [3:0] user_irq_n,
   input wire logic nmi_n,
   input wire logic core_restart_n,
   input wire logic hold_req_n,
   input wire logic float_all_n,
   input wire logic host_port_wide_select,
   output logic hold_ack_n,
   output logic hold_ack_oe,
   output logic irq_accept_n,
   output logic irq_accept_oe
);
   localparam int CW = 4;
   localparam int ACC_CYC = `DBI_ACC_CYC;
   localparam int ACK_CYC = `DBI_ACK_CYC;

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   // Mode 0: input 0 wins; mode 1: input 3 wins
   function automatic logic [1:0] pick(input logic [3:0] p,
                                       input logic mode);
      logic [1:0] k;
      k = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (!mode && p[i]) begin
            k = 2'(i);
         end
      end
      for (int i = 0; i < 4; i++) begin
         if (mode && p[i]) begin
            k = 2'(i);
         end
      end
      return k;
   endfunction

   dbi_sync_if #(.W(9)) ctl ();
   dbi_sync_if #(.W(39)) bus ();

   assign ctl.raw = {host_port_wide_select, float_all_n, hold_req_n,
                     core_restart_n, nmi_n, user_irq_n};
   assign bus.raw = {data_in, addr_in};

   dbi_pin_sync #(.W(9), .INIT(9'h0FF)) u_ctl_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pins(ctl)
   );

   dbi_pin_sync #(.W(39), .INIT(39'h0)) u_bus_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pins(bus)
   );

   logic [3:0] irq_fall;
   logic nmi_fall;
   logic restart_act;
   logic hold_act;
   logic float_act;
   logic host_wide;
   logic [22:0] addr_sync;
   logic [15:0] data_sync;

   assign irq_fall = ctl.fall[3:0];
   assign nmi_fall = ctl.fall[4];
   assign restart_act = ~ctl.level[5];
   assign hold_act = ~ctl.level[6];
   assign float_act = ~ctl.level[7];
   assign host_wide = ctl.level[8];
   assign addr_sync = bus.level[22:0];
   assign data_sync = bus.level[38:23];

   dbi_pkg::dbi_state_e state_r;
   dbi_pkg::dbi_space_e xspace_r;
   dbi_pkg::dbi_space_e acc_space_r;
   logic [CW-1:0] cnt_r;
   logic gim_r;
   logic mode_r;
   logic [3:0] imr_r;
   logic [3:0] ifr_r;
   logic nmi_pend_r;
   logic dhold_r;
   logic [22:0] xaddr_r;
   logic [15:0] xwdata_r;
   logic xwr_r;
   logic acc_wr_r;
   logic cmd_pend_r;
   logic [15:0] xrdata_r;
   logic [22:0] pc_r;
   logic [16:0] haddr_r;
   logic [3:0] evt_r;
   logic [3:0] evtmsk_r;
   logic restart_q_r;
   logic done_r;
   logic [31:0] rdata_r;
   logic [22:0] addr_out_r;
   logic [15:0] data_out_r;

   // Bus slave: one wait state, taken at the second edge
   logic req;
   logic wr_go;
   logic rd_go;
   logic [31:0] rd_word;
   logic [31:0] wmask;
   logic [31:0] wval;

   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~done_r;
   assign wr_go = avs_write & done_r;
   assign rd_go = avs_read & done_r;
   assign wmask = be_mask(avs_byteenable);
   assign wval = (rd_word & ~wmask) | (avs_writedata & wmask);
   assign avs_readdata = rdata_r;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         done_r <= 1'b0;
      end else begin
         done_r <= req & ~done_r;
      end
   end

   always_comb begin
      rd_word = 32'h0;
      unique case (avs_address)
         `DBI_OFS_CTRL: rd_word = {30'h0, mode_r, gim_r};
         `DBI_OFS_IMR: rd_word = {28'h0, imr_r};
         `DBI_OFS_IFR: rd_word = {27'h0, nmi_pend_r, ifr_r};
         `DBI_OFS_BANK_SWITCH_CTRL_REG: rd_word = {31'h0, dhold_r};
         `DBI_OFS_XADDR: rd_word = {9'h0, xaddr_r};
         `DBI_OFS_XWDATA: rd_word = {16'h0, xwdata_r};
         `DBI_OFS_XCMD: rd_word = {28'h0, cmd_pend_r, xwr_r, xspace_r};
         `DBI_OFS_XRDATA: rd_word = {16'h0, xrdata_r};
         `DBI_OFS_STAT: rd_word = {26'h0, float_act, restart_act,
                                   host_wide,
                                   state_r == dbi_pkg::ST_HOLD,
                                   state_r == dbi_pkg::ST_ACK,
                                   state_r == dbi_pkg::ST_ACC};
         `DBI_OFS_PC: rd_word = {9'h0, pc_r};
         `DBI_OFS_HADDR: rd_word = {15'h0, haddr_r};
         `DBI_OFS_EVT: rd_word = {28'h0, evt_r};
         `DBI_OFS_EVTMSK: rd_word = {28'h0, evtmsk_r};
         default: rd_word = 32'h0;
      endcase
   end

   // Loaded while waiting, so data stand at the taking edge
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_r <= 32'h0;
      end else if (avs_read && !done_r) begin
         rdata_r <= rd_word;
      end
   end

   // Sequencing decisions
   logic idle;
   logic [3:0] user_pend;
   logic user_ok;
   logic [1:0] user_idx;
   logic take_nmi;
   logic take_user;
   logic take_cmd;
   logic acc_end;
   logic [22:0] ack_vec;

   assign idle = (state_r == dbi_pkg::ST_IDLE) & ~restart_act & ~hold_act;
   assign user_pend = ifr_r & imr_r;
   assign user_ok = ~gim_r & (|user_pend);
   assign user_idx = pick(user_pend, mode_r);
   assign take_nmi = idle & nmi_pend_r;
   assign take_user = idle & ~nmi_pend_r & user_ok;
   assign take_cmd = idle & ~nmi_pend_r & ~user_ok & cmd_pend_r
                     & ~host_wide;
   assign acc_end = (state_r == dbi_pkg::ST_ACC) && (cnt_r == '0);
   assign ack_vec = nmi_pend_r ? `DBI_VEC_NMI
                    : `DBI_VEC_USER + {19'h0, user_idx, 2'h0};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= dbi_pkg::ST_IDLE;
         cnt_r <= '0;
      end else if (restart_act) begin
         state_r <= dbi_pkg::ST_IDLE;
         cnt_r <= '0;
      end else begin
         unique case (state_r)
            dbi_pkg::ST_IDLE: begin
               if (hold_act) begin
                  state_r <= dbi_pkg::ST_HOLD;
               end else if (take_nmi || take_user) begin
                  state_r <= dbi_pkg::ST_ACK;
                  cnt_r <= CW'(ACK_CYC - 1);
               end else if (take_cmd) begin
                  state_r <= dbi_pkg::ST_ACC;
                  cnt_r <= CW'(ACC_CYC - 1);
               end
            end
            dbi_pkg::ST_ACC, dbi_pkg::ST_ACK: begin
               if (cnt_r == '0) begin
                  state_r <= dbi_pkg::ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            dbi_pkg::ST_HOLD: begin
               if (!hold_act) begin
                  state_r <= dbi_pkg::ST_IDLE;
               end
            end
            default: state_r <= dbi_pkg::ST_IDLE;
         endcase
      end
   end

   // Software control registers
   always_ff @(posedge clk) begin
      if (!reset_n || restart_act) begin
         {mode_r, gim_r} <= `DBI_CTRL_RST;
         imr_r <= 4'h0;
         dhold_r <= `DBI_BANK_SWITCH_CTRL_REG_RST;
         evtmsk_r <= 4'h0;
      end else begin
         if (wr_go && avs_address == `DBI_OFS_CTRL) begin
            gim_r <= wval[`DBI_CTRL_GIM];
            mode_r <= wval[`DBI_CTRL_MODE];
         end else if (take_nmi || take_user) begin
            gim_r <= 1'b1;
         end
         if (wr_go && avs_address == `DBI_OFS_IMR) begin
            imr_r <= wval[3:0];
         end
         if (wr_go && avs_address == `DBI_OFS_BANK_SWITCH_CTRL_REG) begin
            dhold_r <= wval[`DBI_BANK_SWITCH_CTRL_REG_DHOLD];
         end
         if (wr_go && avs_address == `DBI_OFS_EVTMSK) begin
            evtmsk_r <= wval[3:0];
         end
      end
   end

   // flags set on falling edge, cleared by write of one
   logic [3:0] ifr_clr;
   assign ifr_clr = ((wr_go && avs_address == `DBI_OFS_IFR)
                     ? avs_writedata[3:0] & wmask[3:0] : 4'h0)
                    | (take_user ? 4'h1 << user_idx : 4'h0);

   always_ff @(posedge clk) begin
      if (!reset_n || restart_act) begin
         ifr_r <= 4'h0;
         nmi_pend_r <= 1'b0;
      end else begin
         ifr_r <= (ifr_r & ~ifr_clr) | irq_fall;
         nmi_pend_r <= (nmi_pend_r & ~take_nmi) | nmi_fall;
      end
   end

   // External access command; a new command while one waits replaces it
   logic cmd_set;
   assign cmd_set = wr_go && avs_address == `DBI_OFS_XCMD
                    && avs_byteenable[0];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         xaddr_r <= 23'h0;
         xwdata_r <= 16'h0;
         xspace_r <= dbi_pkg::SP_PROG;
         xwr_r <= 1'b0;
         cmd_pend_r <= 1'b0;
      end else begin
         if (wr_go && avs_address == `DBI_OFS_XADDR) begin
            xaddr_r <= wval[22:0];
         end
         if (wr_go && avs_address == `DBI_OFS_XWDATA) begin
            xwdata_r <= wval[15:0];
         end
         if (cmd_set) begin
            xspace_r <= dbi_pkg::dbi_space_e'(wval[1:0]);
            xwr_r <= wval[`DBI_XCMD_WR];
         end
         cmd_pend_r <= cmd_set | (cmd_pend_r & ~take_cmd);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         acc_space_r <= dbi_pkg::SP_PROG;
         acc_wr_r <= 1'b0;
         xrdata_r <= 16'h0;
      end else begin
         if (take_cmd) begin
            acc_space_r <= xspace_r;
            acc_wr_r <= xwr_r;
         end
         if (acc_end && !acc_wr_r) begin
            xrdata_r <= data_sync;
         end
      end
   end

   // fetch address set to reset vector, loaded with the vector on acceptance
   always_ff @(posedge clk) begin
      if (!reset_n || restart_act) begin
         pc_r <= `DBI_VEC_RESET;
      end else if (take_nmi || take_user) begin
         pc_r <= ack_vec;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         haddr_r <= 17'h0;
      end else if (host_wide) begin
         haddr_r <= addr_sync[16:0];
      end
   end

   // Events: read clears only what the read returned
   logic [3:0] evt_set;
   logic [3:0] evt_clr;
   assign evt_set = {restart_q_r & ~restart_act, take_nmi, take_user,
                     acc_end};
   assign evt_clr = (rd_go && avs_address == `DBI_OFS_EVT)
                    ? rdata_r[3:0] : 4'h0;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evt_r <= 4'h0;
         restart_q_r <= 1'b0;
      end else begin
         evt_r <= (evt_r & ~evt_clr) | evt_set;
         restart_q_r <= restart_act;
      end
   end

   assign irq = |(evt_r & evtmsk_r);

   // Pin values; undriven lines follow the wire so the holder keeps it
   logic drive_ok;
   logic in_acc;
   logic in_ack;
   logic [22:0] oe_base;
   logic [22:0] host_mask;

   assign drive_ok = ~float_act & ~restart_act;
   assign in_acc = state_r == dbi_pkg::ST_ACC;
   assign in_ack = state_r == dbi_pkg::ST_ACK;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         addr_out_r <= 23'h0;
      end else if (take_cmd) begin
         addr_out_r <= xaddr_r;
      end else if (take_nmi || take_user) begin
         addr_out_r <= ack_vec;
      end else if (!in_acc && !in_ack) begin
         addr_out_r <= addr_sync;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         data_out_r <= 16'h0;
      end else if (take_cmd && xwr_r) begin
         data_out_r <= xwdata_r;
      end else if (!(in_acc && acc_wr_r)) begin
         data_out_r <= data_sync;
      end
   end

   always_comb begin
      oe_base = 23'h0;
      if (in_acc) begin
         oe_base[15:0] = 16'hFFFF;
         if (acc_space_r == dbi_pkg::SP_PROG) begin
            oe_base[22:16] = 7'h7F;
         end
      end else if (in_ack) begin
         oe_base[15:0] = 16'hFFFF;
      end
   end

   assign host_mask = host_wide ? 23'h01FFFF : 23'h0;
   assign addr_oe = drive_ok ? oe_base & ~host_mask : 23'h0;
   assign addr_out = addr_out_r;

   assign data_oe = drive_ok & ~hold_act & in_acc & acc_wr_r;
   assign data_out = data_out_r;
   assign data_hold_en = dhold_r & ~data_oe;

   assign irq_accept_n = ~in_ack;
   assign irq_accept_oe = ~float_act;
   assign hold_ack_n = ~(state_r == dbi_pkg::ST_HOLD);
   assign hold_ack_oe = ~float_act;
endmodule

// file: hw/dbi_pkg.sv
// Types shared by the bus and interrupt pin block.
// Assumes nothing beyond the register header.
package dbi_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ACC = 4'h2,
      ST_ACK = 4'h4,
      ST_HOLD = 4'h8
   } dbi_state_e;
   typedef enum logic [1:0] {
      SP_PROG = 2'h0,
      SP_DATA = 2'h1,
      SP_IO = 2'h2,
      SP_RSVD = 2'h3
   } dbi_space_e;
endpackage

// file: hw/dbi_regs.svh
// Register map, field positions, reset values and timing counts.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef DBI_REGS_SVH
`define DBI_REGS_SVH

`define DBI_OFS_CTRL 6'h00
`define DBI_OFS_IMR 6'h04
`define DBI_OFS_IFR 6'h08
`define DBI_OFS_BANK_SWITCH_CTRL_REG 6'h0C
`define DBI_OFS_XADDR 6'h10
`define DBI_OFS_XWDATA 6'h14
`define DBI_OFS_XCMD 6'h18
`define DBI_OFS_XRDATA 6'h1C
`define DBI_OFS_STAT 6'h20
`define DBI_OFS_PC 6'h24
`define DBI_OFS_HADDR 6'h28
`define DBI_OFS_EVT 6'h2C
`define DBI_OFS_EVTMSK 6'h30

`define DBI_CTRL_GIM 0
`define DBI_CTRL_MODE 1
`define DBI_BANK_SWITCH_CTRL_REG_DHOLD 0
`define DBI_XCMD_WR 2
`define DBI_XCMD_PEND 3

`define DBI_CTRL_RST 2'h1
`define DBI_BANK_SWITCH_CTRL_REG_RST 1'h1
`define DBI_VEC_RESET 23'h00FF80
`define DBI_VEC_NMI 23'h00FF88
`define DBI_VEC_USER 23'h00FFC0

`define DBI_CLK_MHZ 25
`define DBI_ACC_NS 120
`define DBI_ACC_CYC ((`DBI_ACC_NS * `DBI_CLK_MHZ + 999) / 1000)
`define DBI_ACK_NS 80
`define DBI_ACK_CYC ((`DBI_ACK_NS * `DBI_CLK_MHZ + 999) / 1000)

`endif

// file: hw/dbi_sync_if.sv
// Raw pin group and its synchronised view.
// Assumes the raw side is asynchronous to clk.
interface dbi_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] level;
   logic [W-1:0] fall;
   modport sync (input raw, output level, output fall);
   modport user (output raw, input level, input fall);
endinterface

// file: testbench/dbi_mem_model.sv
// External memory and host model on the address and data pins.
// Assumes 16 words, indexed by the low four address bits.
module dbi_mem_model (
   input wire logic clk,
   input wire logic [22:0] addr_out,
   input wire logic [22:0] addr_oe,
   input wire logic [15:0] data_out,
   input wire logic data_oe,
   input wire logic data_hold_en,
   input wire logic host_sel,
   input wire logic [16:0] host_addr,
   output logic [22:0] addr_in,
   output logic [15:0] data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [16];
   logic [22:0] aw_r;
   logic [15:0] dw_r;
   logic [3:0] idx_r;
   logic [1:0] cnt_r;
   // Known start levels, so undriven lines never read as unknown
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h0;
      aw_r = 23'h0;
      dw_r = 16'h0;
      idx_r = 4'h0;
      cnt_r = 2'h0;
   end
   always_comb begin
      addr_in = (addr_oe & addr_out) | (~addr_oe & aw_r);
      if (host_sel)
         addr_in[16:0] = host_addr;
   end
   // without holder a float toggles, never a stale value
   always_comb begin
      if (data_oe)
         data_in = data_out;
      else if (|addr_oe[15:0])
         data_in = mem[addr_out[3:0]];
      else if (cnt_r != 2'h0)
         data_in = mem[idx_r];
      else if (data_hold_en)
         data_in = dw_r;
      else
         data_in = ~dw_r;
   end
   always @(posedge clk) begin
      aw_r <= addr_in;
      dw_r <= data_in;
      if (|addr_oe[15:0])
         idx_r <= addr_out[3:0];
      cnt_r <= (|addr_oe[15:0] && !data_oe) ? 2'h3 : cnt_r - (cnt_r != 2'h0);
      if (data_oe)
         mem[addr_out[3:0]] <= data_out;
   end
endmodule

// file: testbench/dbi_pins_chk.sv
// Pin timing checker for the bus and interrupt pin block.
// Assumes binding onto dbi_pins; all properties on clk.
module dbi_pins_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [22:0] addr_out,
   input wire logic [22:0] addr_oe,
   input wire logic data_oe,
   input wire logic irq_accept_n,
   input wire logic irq_accept_oe,
   input wire logic hold_ack_n,
   input wire logic hold_ack_oe,
   input wire logic float_all_n,
   input wire logic host_port_wide_select,
   input wire logic core_restart_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Three edges leave room for the two-flop synchroniser
   float_bus_a:
   assert property (!float_all_n [*3] |-> addr_oe == 23'h0 && !data_oe)
      else $error("bus driven while float-all low");
   float_ack_a:
   assert property (!float_all_n [*3] |-> !irq_accept_oe && !hold_ack_oe)
      else $error("acknowledge driven while float-all low");
   hold_release_a:
   assert property (!hold_ack_n |-> addr_oe == 23'h0 && !data_oe)
      else $error("bus driven in hold");
   upper_prog_a:
   assert property (|addr_oe[22:16] |-> irq_accept_n &&
      addr_oe[15:0] == 16'hFFFF)
      else $error("upper lines driven outside an access");
   ack_len_a:
   assert property ($fell(irq_accept_n) |=> !irq_accept_n ##1 irq_accept_n)
      else $error("acknowledge not two cycles");
   ack_vec_a:
   assert property (!irq_accept_n |-> addr_oe[15:0] == 16'hFFFF &&
      addr_out[15:8] == 8'hFF)
      else $error("no vector during acknowledge");
   data_len_a:
   assert property ($rose(data_oe) |-> data_oe [*3] ##1 !data_oe)
      else $error("data drive not three cycles");
   host_input_a:
   assert property (host_port_wide_select [*3] |-> addr_oe[16:0] == 17'h0)
      else $error("host address lines driven");
   restart_idle_a:
   assert property (!core_restart_n [*3] |-> addr_oe == 23'h0 && !data_oe
      && hold_ack_n)
      else $error("activity during restart");

   cover property ($fell(irq_accept_n));
   cover property ($rose(data_oe));
   cover property ($fell(hold_ack_n));
endmodule

bind dbi_pins dbi_pins_chk dbi_pins_chk_i (.clk, .reset_n, .addr_out,
   .addr_oe, .data_oe, .irq_accept_n, .irq_accept_oe, .hold_ack_n,
   .hold_ack_oe, .float_all_n, .host_port_wide_select, .core_restart_n);

// file: testbench/testbench.sv
// Self-checking bench for the bus and interrupt pin block.
// Assumes the memory model answers on the external pins.
`include "dbi_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [5:0] avs_address = 6'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rq;
   logic avs_waitrequest, irq, data_oe, data_hold_en;
   logic [22:0] addr_in, addr_out, addr_oe;
   logic [15:0] data_in, data_out;
   logic [3:0] user_irq_n = 4'hF;
   logic nmi_n = 1'b1;
   logic core_restart_n = 1'b1;
   logic hold_req_n = 1'b1;
   logic float_all_n = 1'b1;
   logic host_port_wide_select = 1'b0;
   logic hold_ack_n, hold_ack_oe, irq_accept_n, irq_accept_oe;
   int num_errors = 0;
   int cmp_count = 0;

   always #20 clk = ~clk;

   dbi_pins dbi_pins_i (.clk, .reset_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
      .avs_waitrequest, .irq, .addr_in, .addr_out, .addr_oe, .data_in,
      .data_out, .data_oe, .data_hold_en, .user_irq_n, .nmi_n,
      .core_restart_n, .hold_req_n, .float_all_n, .host_port_wide_select,
      .hold_ack_n, .hold_ack_oe, .irq_accept_n, .irq_accept_oe);
   dbi_mem_model dbi_mem_model_i (.clk, .addr_out, .addr_oe, .data_out,
      .data_oe, .data_hold_en, .host_sel(host_port_wide_select),
      .host_addr(17'h1ABCD), .addr_in, .data_in);

   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t ns: got %h want %h", $time, g, e);
      end
   endtask

   task finish_test();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Request held until waitrequest is low at an edge
   task av(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      // Waitrequest and read data taken at the same rising edge
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rq = avs_readdata;
      chk(n < 50, 1'b1);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task wait_ack(input logic [15:0] vec);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq_accept_n !== 1'b0 && n < 60);
      chk(addr_out[15:0], vec);
      repeat (4) @(posedge clk);
   endtask

   task pulse(input logic [3:0] u);
      @(posedge clk);
      user_irq_n <= u;
      repeat (4) @(posedge clk);
      user_irq_n <= 4'hF;
      repeat (4) @(posedge clk);
   endtask

   task acc(input logic [22:0] a, input logic [1:0] sp, input logic wr,
      input logic [15:0] d);
      int n;
      av(1'b1, `DBI_OFS_XADDR, {9'h0, a});
      av(1'b1, `DBI_OFS_XWDATA, {16'h0, d});
      av(1'b1, `DBI_OFS_XCMD, {29'h0, wr, sp});
      n = 0;
      while (addr_oe[0] !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(addr_oe, sp == 2'h0 ? 23'h7FFFFF : 23'h00FFFF);
      chk(addr_out[15:0], a[15:0]);
      chk(data_oe, wr);
      chk(wr ? data_out : 16'h0, wr ? d : 16'h0);
      repeat (8) @(posedge clk);
   endtask

   task t_regs();
      av(1'b0, `DBI_OFS_CTRL, 32'h0);
      chk(rq, 32'h1);
      av(1'b0, `DBI_OFS_PC, 32'h0);
      chk(rq, 32'h00FF80);
      av(1'b0, 6'h3C, 32'h0);
      chk(rq, 32'h0);
      chk(data_hold_en, 1'b1);
      av(1'b1, `DBI_OFS_BANK_SWITCH_CTRL_REG, 32'h0);
      @(negedge clk);
      chk(data_hold_en, 1'b0);
      av(1'b1, `DBI_OFS_BANK_SWITCH_CTRL_REG, 32'h1);
      $display("register test done");
   endtask

   task t_acc();
      acc(23'h5A003, 2'h0, 1'b1, 16'hBEEF);
      acc(23'h00005, 2'h2, 1'b1, 16'h1234);
      acc(23'h00013, 2'h1, 1'b0, 16'h0);
      av(1'b0, `DBI_OFS_XRDATA, 32'h0);
      chk(rq, 32'hBEEF);
      acc(23'h00025, 2'h2, 1'b0, 16'h0);
      av(1'b0, `DBI_OFS_XRDATA, 32'h0);
      chk(rq, 32'h1234);
      $display("access test done");
   endtask

   task t_irq();
      av(1'b1, `DBI_OFS_IMR, 32'hF);
      av(1'b1, `DBI_OFS_EVTMSK, 32'h2);
      pulse(4'hA);
      av(1'b0, `DBI_OFS_IFR, 32'h0);
      chk(rq[3:0], 4'h5);
      chk(irq_accept_n, 1'b1);
      av(1'b1, `DBI_OFS_CTRL, 32'h0);
      wait_ack(16'hFFC0);
      chk(irq, 1'b1);
      av(1'b0, `DBI_OFS_IFR, 32'h0);
      chk(rq[3:0], 4'h4);
      av(1'b0, `DBI_OFS_EVT, 32'h0);
      @(negedge clk);
      chk(irq, 1'b0);
      av(1'b1, `DBI_OFS_CTRL, 32'h0);
      wait_ack(16'hFFC8);
      av(1'b1, `DBI_OFS_CTRL, 32'h3);
      pulse(4'h5);
      av(1'b1, `DBI_OFS_IMR, 32'h7);
      av(1'b1, `DBI_OFS_CTRL, 32'h2);
      wait_ack(16'hFFC4);
      av(1'b1, `DBI_OFS_IFR, 32'h8);
      av(1'b0, `DBI_OFS_IFR, 32'h0);
      chk(rq[3:0], 4'h0);
      @(posedge clk);
      nmi_n <= 1'b0;
      wait_ack(16'hFF88);
      nmi_n <= 1'b1;
      $display("interrupt test done");
   endtask

   task t_pins();
      @(posedge clk);
      // far side asks for the bus
      hold_req_n <= 1'b0;
      repeat (6) @(negedge clk);
      chk(hold_ack_n, 1'b0);
      chk(addr_oe, 23'h0);
      av(1'b0, `DBI_OFS_STAT, 32'h0);
      chk(rq, 32'h4);
      @(posedge clk);
      hold_req_n <= 1'b1;
      float_all_n <= 1'b0;
      repeat (4) @(negedge clk);
      chk(irq_accept_oe, 1'b0);
      chk(data_oe, 1'b0);
      @(posedge clk);
      float_all_n <= 1'b1;
      host_port_wide_select <= 1'b1;
      repeat (5) @(posedge clk);
      av(1'b0, `DBI_OFS_HADDR, 32'h0);
      chk(rq, 32'h1ABCD);
      av(1'b1, `DBI_OFS_XCMD, 32'h1);
      repeat (8) @(posedge clk);
      av(1'b0, `DBI_OFS_XCMD, 32'h0);
      chk(rq[3], 1'b1);
      host_port_wide_select <= 1'b0;
      repeat (20) @(posedge clk);
      av(1'b0, `DBI_OFS_XCMD, 32'h0);
      chk(rq[3], 1'b0);
      $display("pin test done");
   endtask

   task t_restart();
      @(posedge clk);
      core_restart_n <= 1'b0;
      repeat (6) @(posedge clk);
      core_restart_n <= 1'b1;
      repeat (5) @(posedge clk);
      av(1'b0, `DBI_OFS_PC, 32'h0);
      chk(rq, 32'h00FF80);
      av(1'b0, `DBI_OFS_IMR, 32'h0);
      chk(rq, 32'h0);
      av(1'b0, `DBI_OFS_EVT, 32'h0);
      chk(rq[3], 1'b1);
      $display("restart test done");
   endtask

   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_acc();
      t_irq();
      t_pins();
      t_restart();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      finish_test();
   end
endmodule
